// [serial_baud_rate_generator.v]
`include "baud_gen_defs.vh"

// How it works
// RL1: With sync, wide enable and high speed clear, one tick comes every 64 times (low byte plus one) clocks.
// RL2: Asynchronous with exactly one of wide enable and high speed set, the period is 16 times (divisor plus one).
// RL3: Synchronous mode ignores high speed and gives 4 times (divisor plus one), 8- or 16-bit per wide enable.
// RL4: The divisor is the high byte in bits 15 to 8 and the low byte in bits 7 to 0.
// RL5: Synchronous mode is bit 4 and high speed is bit 2 of the transmit status and control register.
// RL6: Wide enable is bit 3 of baud control and selects the full 16-bit divisor instead of the low byte.
// RL7: Asynchronous with wide enable and high speed set gives 4 times (divisor plus one), reloaded at terminal count.
module serial_baud_rate_generator (
    input wire i_clock,
    input wire i_srst,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg o_baud_tick,
    output reg o_sync_mode
);

    // Software-visible register bytes.
    reg [7:0] baud_divisor_low_reg;
    reg [7:0] baud_divisor_high_reg;
    reg [7:0] baud_control_reg;
    reg [7:0] transmit_status_control_reg;

    // Bus handshake state and the combinational values that feed the flip-flops.
    reg ack_reg;
    reg [31:0] read_word_next;
    reg [6:0] prescale_next;
    reg [15:0] baud_divisor_next;

    // Decoded request and write strobes.
    wire request;
    wire commit_write;
    wire write_divisor_low;
    wire write_divisor_high;
    wire write_baud_control;
    wire write_tx_status_control;

    // Mode bits pulled out of the control registers, and the divider's raw tick.
    wire wide_divider_enable;
    wire high_speed_select;
    wire sync_mode;
    wire tick;

    // Merge write data into a byte register under its writable-bit mask, so that
    // read-only bits keep reading zero whatever software writes to them.
    function [7:0] merge_byte;
        input [7:0] old_value;
        input [7:0] new_value;
        input [7:0] mask;
        begin
            merge_byte = (old_value & ~mask) | (new_value & mask);
        end
    endfunction

    // True when the bus address selects the given register offset.
    function address_hit;
        input [3:0] address;
        input [3:0] offset;
        begin
            address_hit = (address == offset);
        end
    endfunction

    // Zero-extend a register byte to the bus word; the upper lanes always read zero.
    function [31:0] lane_word;
        input [7:0] value;
        begin
            lane_word = {24'h000000, value};
        end
    endfunction

    // Mode bits sit at fixed positions in their registers.
    assign wide_divider_enable = baud_control_reg[`BIT_WIDE_DIVIDER_ENABLE]; // RL6
    assign sync_mode = transmit_status_control_reg[`BIT_SYNC_MODE]; // RL5
    assign high_speed_select = transmit_status_control_reg[`BIT_HIGH_SPEED_SELECT]; // RL5

    // A request is new when it is seen outside the acknowledge cycle. A write is
    // committed on the acknowledge edge, the one at which the master samples
    // waitrequest low, so a request that is still pending never changes a register.
    assign request = (i_avs_read || i_avs_write) && !ack_reg;
    assign commit_write = i_avs_write && ack_reg && i_avs_byteenable[0];
    assign write_divisor_low = commit_write && address_hit(i_avs_address, `ADDR_DIVISOR_LOW);
    assign write_divisor_high = commit_write && address_hit(i_avs_address, `ADDR_DIVISOR_HIGH);
    assign write_baud_control = commit_write && address_hit(i_avs_address, `ADDR_BAUD_CONTROL);
    assign write_tx_status_control = commit_write && address_hit(i_avs_address, `ADDR_TX_STATUS_CONTROL);

    // One wait cycle per access: waitrequest drops for the single cycle after the
    // request is seen. The trade is a fixed two-edge access for a fully registered
    // waitrequest with no combinational path from the request inputs.
    always @(posedge i_clock) begin
        if (i_srst) begin
            ack_reg <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            ack_reg <= request;
            o_avs_waitrequest <= !request;
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    // The address is decoded in full, so byte offsets inside a word also read zero.
    always @* begin
        read_word_next = 32'h00000000;
        case (i_avs_address)
            `ADDR_DIVISOR_LOW: read_word_next = lane_word(baud_divisor_low_reg);
            `ADDR_DIVISOR_HIGH: read_word_next = lane_word(baud_divisor_high_reg);
            `ADDR_BAUD_CONTROL: read_word_next = lane_word(baud_control_reg);
            `ADDR_TX_STATUS_CONTROL: read_word_next = lane_word(transmit_status_control_reg);
            default: read_word_next = 32'h00000000;
        endcase
    end

    // Read data is captured when the request is seen and then stands through the
    // acknowledge cycle and until the next request. A write clears it.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_avs_readdata <= 32'h00000000;
        end else if (request) begin
            if (i_avs_read) begin
                o_avs_readdata <= read_word_next;
            end else begin
                o_avs_readdata <= 32'h00000000;
            end
        end
    end

    // Divisor low byte: all eight bits are writable.
    // A new value reaches the counter only at its next reload.
    always @(posedge i_clock) begin
        if (i_srst) begin
            baud_divisor_low_reg <= `RESET_DIVISOR_LOW;
        end else if (write_divisor_low) begin
            baud_divisor_low_reg <= i_avs_writedata[7:0]; // RL4
        end
    end

    // Divisor high byte: writable at any time, but only used while wide enable is set.
    // There is no atomic pairing with the low byte, so software writes both before use.
    always @(posedge i_clock) begin
        if (i_srst) begin
            baud_divisor_high_reg <= `RESET_DIVISOR_HIGH;
        end else if (write_divisor_high) begin
            baud_divisor_high_reg <= i_avs_writedata[7:0]; // RL4
        end
    end

    // Baud control: only the wide enable bit is writable; the rest read zero.
    always @(posedge i_clock) begin
        if (i_srst) begin
            baud_control_reg <= `RESET_BAUD_CONTROL;
        end else if (write_baud_control) begin
            baud_control_reg <= merge_byte(baud_control_reg, i_avs_writedata[7:0], `MASK_BAUD_CONTROL); // RL6
        end
    end

    // Transmit status and control: only the synchronous and high speed bits are kept.
    // The transmitter bits of this register live elsewhere and read zero here.
    always @(posedge i_clock) begin
        if (i_srst) begin
            transmit_status_control_reg <= `RESET_TX_STATUS_CONTROL;
        end else if (write_tx_status_control) begin
            transmit_status_control_reg <= merge_byte(transmit_status_control_reg,
                i_avs_writedata[7:0], `MASK_TX_STATUS_CONTROL); // RL5
        end
    end

    // Mode decode picks the prescale ratio. Synchronous mode is tested first because
    // it overrides high speed; the async wide plus high speed case has a row of its own.
    always @* begin
        if (sync_mode) begin
            prescale_next = `PRESCALE_FAST; // RL3
        end else if (wide_divider_enable && high_speed_select) begin
            prescale_next = `PRESCALE_FAST; // RL7
        end else if (wide_divider_enable || high_speed_select) begin
            prescale_next = `PRESCALE_MEDIUM; // RL2
        end else begin
            prescale_next = `PRESCALE_SLOW; // RL1
        end
    end

    // The wide enable decides whether the high byte takes part in the divisor.
    always @* begin
        if (wide_divider_enable) begin
            baud_divisor_next = {baud_divisor_high_reg, baud_divisor_low_reg}; // RL4
        end else begin
            baud_divisor_next = {8'h00, baud_divisor_low_reg}; // RL6
        end
    end

    // The divider runs from reset regardless of mode; a changed divisor waits for the
    // running period to end, while a changed prescale ratio takes effect at once.
    baud_divider #(
        .DIV_WIDTH(16)
    ) baud_divider_i (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_prescale(prescale_next),
        .i_divisor(baud_divisor_next),
        .o_tick(tick)
    );

    // Outputs are registered once more so every top port comes from a flip-flop; the
    // tick therefore trails the divider's internal terminal count by one clock.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_baud_tick <= 1'b0;
            o_sync_mode <= 1'b0;
        end else begin
            o_baud_tick <= tick;
            o_sync_mode <= sync_mode;
        end
    end

endmodule

// [baud_gen_defs.vh]
`ifndef BAUD_GEN_DEFS_VH
`define BAUD_GEN_DEFS_VH

// Register byte addresses on the byte-addressed bus (byte address = word index * 4).
`define ADDR_DIVISOR_LOW 4'h0
`define ADDR_DIVISOR_HIGH 4'h4
`define ADDR_BAUD_CONTROL 4'h8
`define ADDR_TX_STATUS_CONTROL 4'hC

// Field positions.
`define BIT_WIDE_DIVIDER_ENABLE 3
`define BIT_SYNC_MODE 4
`define BIT_HIGH_SPEED_SELECT 2

// Writable bit masks for the mixed registers.
`define MASK_BAUD_CONTROL 8'h08
`define MASK_TX_STATUS_CONTROL 8'h14

// Reset values.
`define RESET_DIVISOR_LOW 8'h00
`define RESET_DIVISOR_HIGH 8'h00
`define RESET_BAUD_CONTROL 8'h00
`define RESET_TX_STATUS_CONTROL 8'h00

// Prescale counts per divisor step.
`define PRESCALE_SLOW 7'h40
`define PRESCALE_MEDIUM 7'h10
`define PRESCALE_FAST 7'h04

`endif

// [baud_divider.v]
`include "baud_gen_defs.vh"

// Two-stage divider: a prescaler counts the chosen ratio, the divisor
// counter counts divisor+1 prescaler wraps, giving ratio*(divisor+1).
module baud_divider #(
    parameter DIV_WIDTH = 16
) (
    input wire i_clock,
    input wire i_srst,
    input wire [6:0] i_prescale,
    input wire [DIV_WIDTH-1:0] i_divisor,
    output reg o_tick
);

    reg [6:0] pre_reg;
    reg [DIV_WIDTH-1:0] count_reg;
    wire pre_wrap;

    assign pre_wrap = (pre_reg >= i_prescale - 7'h01);

    // The counter reloads from the divisor at terminal count, so a new divisor
    // takes effect at the next period rather than truncating the running one.
    always @(posedge i_clock) begin
        if (i_srst) begin
            pre_reg <= 7'h00;
            count_reg <= {DIV_WIDTH{1'b0}};
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (pre_wrap) begin
                pre_reg <= 7'h00;
                if (count_reg == {DIV_WIDTH{1'b0}}) begin
                    count_reg <= i_divisor; // RL7
                    o_tick <= 1'b1;
                end else begin
                    count_reg <= count_reg - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
                end
            end else begin
                pre_reg <= pre_reg + 7'h01;
            end
        end
    end

endmodule

// [baud_gen_assertions.sv]
module baud_gen_assertions (
    input wire i_clock,
    input wire i_srst,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire o_baud_tick,
    input wire o_sync_mode
);
    reg [31:0] sh_reg;
    reg [23:0] cnt_reg;
    reg [1:0] qt_reg;
    // Shadow bytes sit at word index times eight; the expected period is worked out from them.
    wire acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address[1:0] == 2'h0;
    wire [4:0] bs = {i_avs_address[3:2], 3'h0};
    wire [7:0] msk = i_avs_address[3] ? (i_avs_address[2] ? 8'h14 : 8'h08) : 8'hFF;
    wire [7:0] rdx = i_avs_address[1:0] == 2'h0 ? sh_reg[bs +: 8] : 8'h00;
    wire [6:0] pre = (sh_reg[28] || sh_reg[19] && sh_reg[26]) ? 7'h04 : (sh_reg[19] ^ sh_reg[26]) ? 7'h10 : 7'h40;
    wire [23:0] per = pre * ({8'h00, sh_reg[19] ? sh_reg[15:8] : 8'h00, sh_reg[7:0]} + 24'h1);
    wire ok = o_baud_tick && qt_reg[1];
    // A rate is judged from the third tick after the last write, because a change waits for a period boundary.
    always @(posedge i_clock) begin
        cnt_reg <= o_baud_tick ? 24'h0 : cnt_reg + 24'h1;
        if (i_srst) begin
            sh_reg <= 32'h0;
            qt_reg <= 2'h0;
        end else if (acc) begin
            sh_reg[bs +: 8] <= i_avs_writedata[7:0] & msk;
            qt_reg <= 2'h0;
        end else if (o_baud_tick && !qt_reg[1]) begin
            qt_reg <= qt_reg + 2'h1;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    a_slow_rate: assert property (ok && pre == 7'h40 |-> cnt_reg == per - 24'h1) else $error("slow rate");
    a_mid_rate: assert property (ok && pre == 7'h10 |-> cnt_reg == per - 24'h1) else $error("mid rate");
    a_sync_rate: assert property (ok && sh_reg[28] |-> cnt_reg == per - 24'h1) else $error("sync rate");
    a_fast_rate: assert property (ok && !sh_reg[28] && pre == 7'h04 |->
        cnt_reg == per - 24'h1) else $error("fast");
    a_read_back: assert property (i_avs_read && !o_avs_waitrequest |->
        o_avs_readdata == {24'h0, rdx}) else $error("rd");
    a_sync_copy: assert property (acc |=> ##1 o_sync_mode == sh_reg[28]) else $error("sync bit");
    a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("ack");
    a_ack_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("ack length");
endmodule
bind serial_baud_rate_generator baud_gen_assertions baud_gen_assertions_i (.i_clock, .i_srst, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .o_baud_tick, .o_sync_mode);

// [tb_serial_baud_rate_generator.sv]
module tb_serial_baud_rate_generator;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, wq, tk, sy;
    logic [3:0] ad = 4'h0, be = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [31:0] rv, q;
    int error_cnt = 0, samples_checked = 0, n;
    // Each row: control byte, status byte, prescale ratio.
    logic [7:0] md [6][3] = '{'{8'h00, 8'h00, 8'h40}, '{8'h00, 8'h04, 8'h10}, '{8'h08, 8'h00, 8'h10},
        '{8'h08, 8'h04, 8'h04}, '{8'h00, 8'h14, 8'h04}, '{8'h08, 8'h10, 8'h04}};
    // The 10 MHz clock.
    initial forever #50 clk = ~clk;
    serial_baud_rate_generator serial_baud_rate_generator_i (.i_clock(clk), .i_srst(srst), .i_avs_address(ad),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata({24'h0, wd}), .i_avs_byteenable(be),
        .o_avs_readdata(rv), .o_avs_waitrequest(wq), .o_baud_tick(tk), .o_sync_mode(sy));
    task chk(input [31:0] s, input [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // The request stands until waitrequest is sampled low; that edge also takes the read data.
    task bus(input [3:0] a, input w, input [7:0] d, input [3:0] b);
        @(posedge clk);
        ad <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        be <= b;
        do begin
            @(posedge clk);
        end while (wq !== 1'b0);
        q = rv;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Counts edges up to the next tick; the watchdog ends the run if the generator is dead.
    task per;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tk !== 1'b1);
    endtask
    task finish_test;
        $display("Compared %0d, mismatched %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well beyond the longest expected run.
    initial begin
        #6000000;
        error_cnt++;
        finish_test;
    end
    // Register access first, then every rate setting measured on the third tick after it.
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        bus(4'h4, 1'b0, 8'h00, 4'h1);
        chk(q, 32'h0);
        bus(4'h8, 1'b1, 8'hFF, 4'h1);
        bus(4'h8, 1'b0, 8'h00, 4'h1);
        chk(q, 32'h8);
        bus(4'hC, 1'b1, 8'hFF, 4'h1);
        bus(4'hC, 1'b0, 8'h00, 4'h1);
        chk(q, 32'h14);
        chk(sy, 1'b1);
        bus(4'h0, 1'b1, 8'h02, 4'h1);
        bus(4'h0, 1'b1, 8'hAA, 4'h0);
        bus(4'h4, 1'b1, 8'h01, 4'h1);
        bus(4'h2, 1'b1, 8'h55, 4'h1);
        bus(4'h2, 1'b0, 8'h00, 4'h1);
        chk(q, 32'h0);
        bus(4'h0, 1'b0, 8'h00, 4'h1);
        chk(q, 32'h2);
        for (int i = 0; i < 6; i++) begin
            bus(4'h8, 1'b1, md[i][0], 4'h1);
            bus(4'hC, 1'b1, md[i][1], 4'h1);
            repeat (3) per;
            chk(n, md[i][2] * (md[i][0][3] ? 16'h103 : 16'h3));
            chk(sy, md[i][1][4]);
        end
        finish_test;
    end
endmodule
